// ---- cgr_global_regs.v ----
// Global configuration and status register group of a four-channel codec.
// Assumes a serial host port upstream delivers decoded command and data
// bytes as one-cycle strobes on the device master clock.
//
// Contract
// - Command bit 7 is write flag; format register read 26H, write A6H.
// - Format bit 7: zero A-law default, one mu-law.
// - Format bit 6: zero compressed default, one linear code.
// - Slope bit 5: zero single bit clock default, one double.
// - Low slope bits choose transmit and receive bit clock edges.
// - Three-bit offset delays slots 0 to 7 bit clocks from frame sync.
// - Ring polarity zero: pin falls to ring; one: pin rises.
// - Hook polarity zero: off-hook input active low; one: active high.
// - Hook select zero: first signal input; one: second signal input.
// - Ring trip enable bit turns hardware ring trip on or off.
// - Ring select picks bidir pin 1-3 if output, or dedicated outputs.
// - Status register: hook bits low nibble, ground key bits high nibble.
// - Bidir register high nibble sets direction per channel, one output.
// - Bidir low nibble reads input pins, drives written value on outputs.
// - Global registers 13 to 17 are reserved without function.
// - Level low byte, read 31H, resets to 00H.
// - Low byte bit 0 set on result ready, cleared after high byte read.
// - Level high byte, read 32H, resets to zero.
`timescale 1ns/1ps
`default_nettype none
`include "cgr_defs.vh"

module cgr_global_regs #(
    parameter CHANNELS = 4                      // Line channels served
) (
    input  wire                  clock,         // Device master clock, 100 MHz
    input  wire                  rst_b,         // Synchronous reset, active low
    input  wire                  cmdValid,      // Command byte strobe
    input  wire [7:0]            cmdByte,       // Command: write flag and address
    input  wire                  wrValid,       // Write data byte strobe
    input  wire [7:0]            wrData,        // Write data byte
    output reg  [7:0]            rdData,        // Read data byte
    output reg                   rdValid,       // Read data valid pulse
    input  wire [CHANNELS-1:0]   hookDebounced,   // Debounced first inputs
    input  wire [CHANNELS-1:0]   groundDebounced, // Debounced second inputs
    input  wire [CHANNELS-1:0]   firstSignalIn,   // Raw first signal inputs
    input  wire [CHANNELS-1:0]   secondSignalIn,  // Raw second signal inputs
    input  wire [CHANNELS-1:0]   ringActive,      // Per-channel ring request
    output wire [CHANNELS-1:0]   offHook,         // Off-hook after select/pol
    output wire [CHANNELS-1:0]   ringTripOffHook, // Off-hook gated by trip en
    input  wire [CHANNELS-1:0]   pinOneIn,        // Bidir pin one inputs
    output wire [CHANNELS-1:0]   pinOneOut,       // Bidir pin one outputs
    output wire [CHANNELS-1:0]   pinOneOe,        // Bidir pin one drive enable
    input  wire [CHANNELS-1:0]   pinTwoIn,        // Bidir pin two inputs
    output wire [CHANNELS-1:0]   pinTwoOut,       // Bidir pin two outputs
    output wire [CHANNELS-1:0]   pinTwoOe,        // Bidir pin two drive enable
    input  wire [CHANNELS-1:0]   pinThreeIn,      // Bidir pin three inputs
    output wire [CHANNELS-1:0]   pinThreeOut,     // Bidir pin three outputs
    output wire [CHANNELS-1:0]   pinThreeOe,      // Bidir pin three drive enable
    input  wire [CHANNELS-1:0]   dedOneBase,      // Dedicated output one level
    input  wire [CHANNELS-1:0]   dedTwoBase,      // Dedicated output two level
    output wire [CHANNELS-1:0]   dedicatedOutputOne, // Dedicated output one
    output wire [CHANNELS-1:0]   dedicatedOutputTwo, // Dedicated output two
    input  wire                  levelResultValid,   // Meter result ready pulse
    input  wire [15:0]           levelResult,        // Meter result word
    output wire                  muLawSel,        // Companding law select
    output wire                  linearVoice,     // Voice data format select
    output wire                  doubleBitClock,  // Double bit clock mode
    output wire                  txOnFalling,     // Transmit on falling edge
    output wire                  rxOnRising,      // Receive on rising edge
    output wire [2:0]            frameSyncOffset, // Slot offset in bit clocks
    output wire                  ringTripEnable   // Hardware ring trip on
);

    // ****************************************
    // Command decode
    // ****************************************
    reg  [6:0] addrQ;
    reg        writeQ;
    reg        armedQ;
    reg  [7:0] fmtQ;
    reg  [7:0] ringQ;
    wire [7:0] pinRegQ [0:2];
    reg  [7:0] lvlLowQ;
    reg  [7:0] lvlHighQ;
    wire       doWrite = wrValid & armedQ & writeQ;
    wire       highRead;

    always @(posedge clock) begin
        if (!rst_b) begin
            addrQ  <= 7'h00;
            writeQ <= 1'b0;
            armedQ <= 1'b0;
        end else if (cmdValid) begin
            addrQ  <= cmdByte[`CGR_ADDR_MSB:0];
            writeQ <= cmdByte[`CGR_CMD_WRITE_BIT];
            armedQ <= cmdByte[`CGR_CMD_WRITE_BIT];
        end else if (wrValid) begin
            armedQ <= 1'b0;
        end
    end

    // ****************************************
    // Writable registers
    // ****************************************
    // Only the read/write addresses accept a write; others drop it
    always @(posedge clock) begin
        if (!rst_b) begin
            fmtQ  <= `CGR_RST_BYTE;
            ringQ <= `CGR_RST_BYTE;
        end else if (doWrite) begin
            if (addrQ == `CGR_ADDR_PCM_FMT)
                fmtQ <= wrData;
            if (addrQ == `CGR_ADDR_RING_CTL) begin
                ringQ <= wrData;
                // Reserved bit kept zero whatever the host sends
                ringQ[`CGR_RING_RSVD] <= 1'b0;
            end
        end
    end

    genvar p;
    generate
        for (p = 0; p < 3; p = p + 1) begin : gPinReg
            // One flop bank per pin register keeps each entry single-driven
            localparam [31:0] PIN_OFS = p;
            reg [7:0] entryQ;
            always @(posedge clock) begin
                if (!rst_b)
                    entryQ <= `CGR_RST_BYTE;
                else if (doWrite && addrQ == `CGR_ADDR_PIN1 + PIN_OFS[6:0])
                    entryQ <= wrData;
            end
            assign pinRegQ[p] = entryQ;
        end
    endgenerate

    // ****************************************
    // Level meter result and ready flag
    // ****************************************
    // A new result wins over a clearing high-byte read in the same cycle
    always @(posedge clock) begin
        if (!rst_b) begin
            lvlLowQ  <= `CGR_RST_BYTE;
            lvlHighQ <= `CGR_RST_BYTE;
        end else if (levelResultValid) begin
            lvlLowQ  <= {levelResult[7:1], 1'b1};
            lvlHighQ <= levelResult[15:8];
        end else if (highRead) begin
            lvlLowQ[`CGR_LVL_READY] <= 1'b0;
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    wire [7:0] sigStat = {groundDebounced, hookDebounced};
    wire [7:0] pinView [0:2];
    wire [CHANNELS-1:0] pinInAll [0:2];
    assign pinInAll[0] = pinOneIn;
    assign pinInAll[1] = pinTwoIn;
    assign pinInAll[2] = pinThreeIn;

    genvar v;
    generate
        for (v = 0; v < 3; v = v + 1) begin : gPinView
            // Inputs show the pin, outputs show the written value
            assign pinView[v] = {pinRegQ[v][7:4],
                (pinRegQ[v][7:4] & pinRegQ[v][3:0]) |
                (~pinRegQ[v][7:4] & pinInAll[v])};
        end
    endgenerate

    reg [7:0] rdMux;
    always @* begin
        case (addrQ)
            `CGR_ADDR_PCM_FMT:  rdMux = fmtQ;
            `CGR_ADDR_RING_CTL: rdMux = ringQ;
            `CGR_ADDR_SIG_STAT: rdMux = sigStat;
            `CGR_ADDR_PIN1:     rdMux = pinView[0];
            `CGR_ADDR_PIN2:     rdMux = pinView[1];
            `CGR_ADDR_PIN3:     rdMux = pinView[2];
            `CGR_ADDR_LVL_LOW:  rdMux = lvlLowQ;
            `CGR_ADDR_LVL_HIGH: rdMux = lvlHighQ;
            default:            rdMux = `CGR_RST_BYTE;
        endcase
    end

    // Read is answered two cycles after the command byte
    reg readPendQ;
    always @(posedge clock) begin
        if (!rst_b) begin
            readPendQ <= 1'b0;
            rdValid   <= 1'b0;
            rdData    <= `CGR_RST_BYTE;
        end else begin
            readPendQ <= cmdValid & ~cmdByte[`CGR_CMD_WRITE_BIT];
            rdValid   <= readPendQ;
            if (readPendQ)
                rdData <= rdMux;
        end
    end

    assign highRead = readPendQ && addrQ == `CGR_ADDR_LVL_HIGH;

    // ****************************************
    // Format and clocking controls
    // ****************************************
    assign muLawSel        = fmtQ[`CGR_FMT_LAW];
    assign linearVoice     = fmtQ[`CGR_FMT_VOICE];
    assign doubleBitClock  = fmtQ[`CGR_FMT_DOUBLE];
    assign txOnFalling     = fmtQ[`CGR_FMT_EDGE_MSB];
    assign rxOnRising      = fmtQ[`CGR_FMT_EDGE_LSB];
    assign frameSyncOffset = fmtQ[`CGR_FMT_OFS_MSB:`CGR_FMT_OFS_LSB];
    assign ringTripEnable  = ringQ[`CGR_TRIP_EN];

    // ****************************************
    // Hook detection
    // ****************************************
    wire [CHANNELS-1:0] hookRaw = ringQ[`CGR_HOOK_SEL] ? secondSignalIn
                                                       : firstSignalIn;
    assign offHook = ringQ[`CGR_HOOK_POL] ? hookRaw : ~hookRaw;
    assign ringTripOffHook = offHook & {CHANNELS{ringTripEnable}};

    // ****************************************
    // Per-channel pin drive and ring routing
    // ****************************************
    genvar c;
    generate
        for (c = 0; c < CHANNELS; c = c + 1) begin : gChan
            wire [2:0] outEn = {pinRegQ[2][4+c], pinRegQ[1][4+c], pinRegQ[0][4+c]};
            wire [2:0] pinOvr;
            wire [1:0] dedOvr;
            wire       ringLvl;
            // Ring request is gated off on trip off-hook so the line is released quickly
            cgr_ring_route uRoute (
                .ringActive  (ringActive[c] & ~ringTripOffHook[c]),
                .ringPolHigh (ringQ[`CGR_RING_POL]),
                .ringSel     (ringQ[`CGR_RSEL_MSB:`CGR_RSEL_LSB]),
                .pinOutEn    (outEn),
                .pinRingOvr  (pinOvr),
                .dedRingOvr  (dedOvr),
                .ringLevel   (ringLvl)
            );
            assign pinOneOe[c]    = outEn[0];
            assign pinTwoOe[c]    = outEn[1];
            assign pinThreeOe[c]  = outEn[2];
            assign pinOneOut[c]   = pinOvr[0] ? ringLvl : pinRegQ[0][c];
            assign pinTwoOut[c]   = pinOvr[1] ? ringLvl : pinRegQ[1][c];
            assign pinThreeOut[c] = pinOvr[2] ? ringLvl : pinRegQ[2][c];
            assign dedicatedOutputOne[c] = dedOvr[0] ? ringLvl : dedOneBase[c];
            assign dedicatedOutputTwo[c] = dedOvr[1] ? ringLvl : dedTwoBase[c];
        end
    endgenerate

endmodule // cgr_global_regs

`default_nettype wire

// ---- cgr_defs.vh ----
// Constants for the codec global configuration register group.
// Assumes inclusion by bare name from the design files of this group.
`ifndef CGR_DEFS_VH
`define CGR_DEFS_VH

// ****************************************
// Command byte layout
// ****************************************
`define CGR_CMD_WRITE_BIT  7
`define CGR_ADDR_MSB       6

// ****************************************
// Register addresses (command low seven bits)
// ****************************************
`define CGR_ADDR_PCM_FMT   7'h26
`define CGR_ADDR_RING_CTL  7'h27
`define CGR_ADDR_SIG_STAT  7'h28
`define CGR_ADDR_PIN1      7'h29
`define CGR_ADDR_PIN2      7'h2A
`define CGR_ADDR_PIN3      7'h2B
`define CGR_ADDR_LVL_LOW   7'h31
`define CGR_ADDR_LVL_HIGH  7'h32

// ****************************************
// Field positions
// ****************************************
`define CGR_FMT_LAW        7
`define CGR_FMT_VOICE      6
`define CGR_FMT_DOUBLE     5
`define CGR_FMT_EDGE_MSB   4
`define CGR_FMT_EDGE_LSB   3
`define CGR_FMT_OFS_MSB    2
`define CGR_FMT_OFS_LSB    0
`define CGR_RING_POL       7
`define CGR_RING_RSVD      6
`define CGR_HOOK_POL       5
`define CGR_HOOK_SEL       4
`define CGR_TRIP_EN        3
`define CGR_RSEL_MSB       2
`define CGR_RSEL_LSB       0
`define CGR_LVL_READY      0

// ****************************************
// Ring output select codes
// ****************************************
`define CGR_RSEL_PIN1      3'h3
`define CGR_RSEL_PIN2      3'h4
`define CGR_RSEL_PIN3      3'h5
`define CGR_RSEL_DED1      3'h6
`define CGR_RSEL_DED2      3'h7

// ****************************************
// Reset values
// ****************************************
`define CGR_RST_BYTE       8'h00
`define CGR_RST_NIBBLE     4'h0

`endif

// ---- cgr_ring_route.v ----
// Ring control routing: one channel's ring drive onto the selected pin.
// Assumes the select code and directions come from the register bank.
`timescale 1ns/1ps
`default_nettype none
`include "cgr_defs.vh"

module cgr_ring_route (
    input  wire       ringActive,   // Channel ring request, high to ring
    input  wire       ringPolHigh,  // Ring drive polarity
    input  wire [2:0] ringSel,      // Ring output select code
    input  wire [2:0] pinOutEn,     // Direction of the three bidir pins
    output reg  [2:0] pinRingOvr,   // Bidir pins taken over by ring
    output reg  [1:0] dedRingOvr,   // Dedicated outputs taken over by ring
    output wire       ringLevel     // Level to drive on the selected pin
);

    // Inactive level is high for falling activation, low otherwise
    assign ringLevel = ringPolHigh ? ringActive : ~ringActive;

    always @* begin
        pinRingOvr = 3'h0;
        dedRingOvr = 2'h0;
        case (ringSel)
            `CGR_RSEL_PIN1: pinRingOvr[0] = pinOutEn[0];
            `CGR_RSEL_PIN2: pinRingOvr[1] = pinOutEn[1];
            `CGR_RSEL_PIN3: pinRingOvr[2] = pinOutEn[2];
            `CGR_RSEL_DED1: dedRingOvr[0] = 1'b1;
            `CGR_RSEL_DED2: dedRingOvr[1] = 1'b1;
            // Undefined codes route the ring nowhere
            default: begin
                pinRingOvr = 3'h0;
                dedRingOvr = 2'h0;
            end
        endcase
    end

endmodule // cgr_ring_route

`default_nettype wire

// ---- cgr_checker.sv ----
// Checker for the codec global register group: answer timing and readback.
// Assumes it is bound to cgr_global_regs and that status inputs hold during reads.
`timescale 1ns/1ps
`default_nettype none
module cgr_checker #(
    parameter CHANNELS = 4                       // Line channels served
) (
    input wire                clock,             // Master clock
    input wire                rst_b,             // Synchronous reset, active low
    input wire                cmdValid,          // Command strobe
    input wire [7:0]          cmdByte,           // Command byte
    input wire                wrValid,           // Write strobe
    input wire [7:0]          wrData,            // Write data
    input wire [7:0]          rdData,            // Read data
    input wire                rdValid,           // Read answer
    input wire [CHANNELS-1:0] hookDebounced,     // Hook status in
    input wire [CHANNELS-1:0] groundDebounced,   // Ground key in
    input wire [CHANNELS-1:0] offHook,           // Off-hook
    input wire [CHANNELS-1:0] ringTripOffHook,   // Gated off-hook
    input wire [CHANNELS-1:0] pinOneOe,          // Pin one enable
    input wire                muLawSel,          // Law select
    input wire                linearVoice,       // Voice format
    input wire                doubleBitClock,    // Double clock
    input wire                txOnFalling,       // Transmit edge
    input wire                rxOnRising,        // Receive edge
    input wire [2:0]          frameSyncOffset,   // Slot offset
    input wire                ringTripEnable     // Ring trip on
);
    // ****************************************
    // Helpers
    // ****************************************
    wire       rdReq = cmdValid & ~cmdByte[7];
    wire [7:0] fmtNow = {muLawSel, linearVoice, doubleBitClock, txOnFalling, rxOnRising,
                         frameSyncOffset};
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    // ****************************************
    // Assertions
    // ****************************************
    a_read_latency: assert property (rdReq |-> ##2 rdValid)
        else $error("read answer missing two cycles after command");
    a_answer_cause: assert property (rdValid |-> $past(rdReq, 2))
        else $error("read answer without read command");
    a_write_visible: assert property (cmdValid && cmdByte == 8'hA6 ##1 wrValid
        |=> fmtNow == $past(wrData)) else $error("format write not reflected");
    a_fmt_readback: assert property (rdValid && $past(cmdByte, 2) == 8'h26
        |-> rdData == fmtNow) else $error("format readback differs from fields");
    a_ring_readback: assert property (rdValid && $past(cmdByte, 2) == 8'h27
        |-> !rdData[6] && rdData[3] == ringTripEnable) else $error("ring readback bad");
    a_status_read: assert property (rdValid && $past(cmdByte, 2) == 8'h28
        |-> rdData == {groundDebounced, hookDebounced}) else $error("status read bad");
    a_reserved_zero: assert property (rdValid && $past(cmdByte, 2) >= 8'h2C
        && $past(cmdByte, 2) <= 8'h30 |-> rdData == 8'h00) else $error("reserved nonzero");
    a_oe_readback: assert property (rdValid && $past(cmdByte, 2) == 8'h29
        |-> rdData[7:4] == pinOneOe) else $error("direction readback bad");
    a_trip_gate: assert property (
        ringTripOffHook == (offHook & {CHANNELS{ringTripEnable}}))
        else $error("ring trip gating wrong");
    a_reset_quiet: assert property ($rose(rst_b) |-> !rdValid && rdData == 8'h00
        && pinOneOe == 0 && fmtNow == 8'h00 && !ringTripEnable) else $error("reset state bad");
endmodule // cgr_checker

bind cgr_global_regs cgr_checker #(.CHANNELS(CHANNELS)) u_chk (.clock(clock), .rst_b(rst_b),
    .cmdValid(cmdValid), .cmdByte(cmdByte), .wrValid(wrValid), .wrData(wrData),
    .rdData(rdData), .rdValid(rdValid), .hookDebounced(hookDebounced),
    .groundDebounced(groundDebounced), .offHook(offHook), .ringTripOffHook(ringTripOffHook),
    .pinOneOe(pinOneOe), .muLawSel(muLawSel), .linearVoice(linearVoice),
    .doubleBitClock(doubleBitClock), .txOnFalling(txOnFalling), .rxOnRising(rxOnRising),
    .frameSyncOffset(frameSyncOffset), .ringTripEnable(ringTripEnable));
`default_nettype wire

// ---- cgr_host_model.sv ----
// Host side of the serial port, as command and data byte strobes.
// Assumes the caller waits for each transfer to end before the next.
`timescale 1ns/1ps
`default_nettype none
module cgr_host_model (
    input  wire logic   clock,     // Master clock
    output logic        cmdValid,  // Command strobe
    output logic [7:0]  cmdByte,   // Command byte
    output logic        wrValid,   // Write strobe
    output logic [7:0]  wrData     // Write data
);
    initial begin
        cmdValid = 1'b0;
        cmdByte  = 8'h00;
        wrValid  = 1'b0;
        wrData   = 8'h00;
    end
    // One command, one data byte for writes; idle gap covers the read answer
    task send(input logic [6:0] a, input logic w, input logic [7:0] d);
        @(negedge clock);
        cmdValid = 1'b1;
        cmdByte  = {w, a};
        @(negedge clock);
        cmdValid = 1'b0;
        wrValid  = w;
        wrData   = d;
        @(negedge clock);
        wrValid = 1'b0;
        wrData  = ~wrData; // Released data never keeps its last value
        repeat (2) @(negedge clock);
    endtask
endmodule // cgr_host_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking bench for the global register group.
// Assumes the host model drives the port and status inputs hold during reads.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock = 1'b0, rst_b = 1'b0, levelResultValid = 1'b0;
    logic [3:0] hookDebounced = 4'h0, groundDebounced = 4'h0, firstSignalIn = 4'h0;
    logic [3:0] secondSignalIn = 4'h0, ringActive = 4'h0;
    logic [3:0] pinIn [3] = '{4'h0, 4'h0, 4'h0};
    logic [15:0] levelResult = 16'h0000;
    logic [6:0] regList [8] = '{7'h26, 7'h27, 7'h28, 7'h29, 7'h2A, 7'h2B, 7'h31, 7'h32};
    wire cmdValid, wrValid, rdValid, muLawSel, linearVoice, doubleBitClock;
    wire txOnFalling, rxOnRising, ringTripEnable;
    wire [7:0] cmdByte, wrData, rdData;
    wire [2:0] frameSyncOffset;
    wire [3:0] offHook, ringTripOffHook, dedicatedOutputOne, dedicatedOutputTwo;
    wire [3:0] pinOut [3], pinOe [3];
    logic [7:0] expQ [$];
    logic [7:0] d;
    logic [3:0] e;
    logic [2:0] s;
    logic p, a, lv;
    int errors = 0, checks_done = 0, cycles = 0, i;

    initial forever #5 clock = ~clock;
    cgr_host_model u_host (.clock(clock), .cmdValid(cmdValid), .cmdByte(cmdByte),
        .wrValid(wrValid), .wrData(wrData));
    cgr_global_regs #(.CHANNELS(4)) u_dut (.clock(clock), .rst_b(rst_b), .cmdValid(cmdValid),
        .cmdByte(cmdByte), .wrValid(wrValid), .wrData(wrData), .rdData(rdData),
        .rdValid(rdValid), .hookDebounced(hookDebounced), .groundDebounced(groundDebounced),
        .firstSignalIn(firstSignalIn), .secondSignalIn(secondSignalIn), .ringActive(ringActive),
        .offHook(offHook), .ringTripOffHook(ringTripOffHook), .pinOneIn(pinIn[0]),
        .pinOneOut(pinOut[0]), .pinOneOe(pinOe[0]), .pinTwoIn(pinIn[1]), .pinTwoOut(pinOut[1]),
        .pinTwoOe(pinOe[1]), .pinThreeIn(pinIn[2]), .pinThreeOut(pinOut[2]),
        .pinThreeOe(pinOe[2]), .dedOneBase(4'h0), .dedTwoBase(4'h0),
        .dedicatedOutputOne(dedicatedOutputOne), .dedicatedOutputTwo(dedicatedOutputTwo),
        .levelResultValid(levelResultValid), .levelResult(levelResult), .muLawSel(muLawSel),
        .linearVoice(linearVoice), .doubleBitClock(doubleBitClock), .txOnFalling(txOnFalling),
        .rxOnRising(rxOnRising), .frameSyncOffset(frameSyncOffset),
        .ringTripEnable(ringTripEnable));

    // ****************************************
    // Checking
    // ****************************************
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task wrap_up;
        if (errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task rd(input logic [6:0] ad, input logic [7:0] ex);
        expQ.push_back(ex);
        u_host.send(ad, 1'b0, 8'h00);
    endtask
    task wr(input logic [6:0] ad, input logic [7:0] dt);
        u_host.send(ad, 1'b1, dt);
    endtask
    // Answers are matched in order against what the driver noted
    always @(negedge clock) begin
        if (rdValid === 1'b1) begin
            if (expQ.size() == 0) chk(rdData, 8'hXX);
            else chk(rdData, expQ.pop_front());
        end
    end
    // Sized for roughly 400 cycles of traffic
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            wrap_up;
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        void'($urandom(32'h0528));
        repeat (20) @(negedge clock);
        rst_b = 1'b1;
        foreach (regList[k])
            rd(regList[k], 8'h00);
        for (i = 0; i < 6; i++) begin
            d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            wr(7'h26, d);
            rd(7'h26, d);
            chk({muLawSel, linearVoice, doubleBitClock, txOnFalling, rxOnRising,
                 frameSyncOffset}, d);
        end
        wr(7'h27, 8'hFF);
        rd(7'h27, 8'hBF);
        chk({7'h0, ringTripEnable}, 8'h01);
        hookDebounced = 4'h5;
        groundDebounced = 4'hA;
        wr(7'h28, 8'h00);
        rd(7'h28, 8'hA5);
        for (i = 8'h2C; i <= 8'h30; i++) begin
            wr(7'(i), 8'hFF);
            rd(7'(i), 8'h00);
        end
        for (i = 0; i < 3; i++) begin
            pinIn[i] = 4'hC;
            wr(7'(8'h29 + i), 8'h53);
            rd(7'(8'h29 + i), 8'h59);
            chk({pinOe[i], pinOut[i] & 4'h5}, 8'h51);
        end
        firstSignalIn = 4'h3;
        secondSignalIn = 4'h5;
        for (i = 0; i < 4; i++) begin
            wr(7'h27, 8'h0E | 8'(i << 4));
            e = i[0] ? 4'h5 : 4'h3;
            e = i[1] ? e : ~e;
            chk({4'h0, offHook}, {4'h0, e});
            chk({4'h0, ringTripOffHook}, {4'h0, e});
        end
        for (i = 0; i < 20; i++) begin
            s = 3'(3 + i % 5);
            p = 1'((i / 5) % 2);
            a = 1'(i / 10);
            wr(7'h27, {p, 4'h0, s});
            @(negedge clock) ringActive = {3'h0, a};
            #1 lv = (s == 3) ? pinOut[0][0] : (s == 4) ? pinOut[1][0] :
                    (s == 5) ? pinOut[2][0] : (s == 6) ? dedicatedOutputOne[0] :
                    dedicatedOutputTwo[0];
            chk({7'h0, lv}, {7'h0, ~(p ^ a)});
        end
        @(negedge clock);
        levelResult = 16'hA5C4;
        levelResultValid = 1'b1;
        @(negedge clock) levelResultValid = 1'b0;
        rd(7'h31, 8'hC5);
        rd(7'h32, 8'hA5);
        rd(7'h31, 8'hC4);
        // Mid-run reset must bring the format, pin one and level low registers back to their defaults
        rst_b = 1'b0;
        repeat (2) @(negedge clock);
        rst_b = 1'b1;
        rd(7'h26, 8'h00);
        rd(7'h29, 8'h0C);
        rd(7'h31, 8'h00);
        repeat (4) @(negedge clock);
        wrap_up;
    end
endmodule // testbench
`default_nettype wire
